// *** rdc_pkg.sv ***
package rdc_pkg;
  localparam int POS_W = 16;
  localparam int BYTE_W = 8;
  localparam int SYNC_STAGES = 2;
  localparam int CLK_PERIOD_NS = 40;
  localparam int FREEZE_NS = 600;
  localparam int FREEZE_CYC = (FREEZE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUSY_MIN_NS = 200;
  localparam int BUSY_CYC = (BUSY_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRAP_MIN_NS = 300;
  localparam int WRAP_CYC = (WRAP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BYTE_NS = 140;
  localparam int BYTE_CYC = (BYTE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_CYC = BYTE_CYC + SYNC_STAGES;
  localparam int LOAD_NS = 300;
  localparam int LOAD_CYC = (LOAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MAX_RPS = 1040;
  localparam int BASE_RES = 10;
  localparam int STEP_GAP_CYC = 1000000000 / (CLK_PERIOD_NS * MAX_RPS * (1 << BASE_RES));
  localparam logic [15:0] MASK10 = 16'h03ff;
  localparam logic [15:0] MASK12 = 16'h0fff;
  localparam logic [15:0] MASK14 = 16'h3fff;
  localparam logic [15:0] MASK16 = 16'hffff;
  localparam int AXI_AW = 6;
  localparam logic [5:0] REG_CTRL = 6'h00;
  localparam logic [5:0] REG_CMD = 6'h04;
  localparam logic [5:0] REG_PRESET = 6'h08;
  localparam logic [5:0] REG_POS = 6'h0c;
  localparam logic [5:0] REG_STATUS = 6'h10;
  localparam logic [5:0] REG_MASK = 6'h14;
  localparam int CTRL_INV = 2;
  localparam logic [2:0] CTRL_RST = 3'h3;
  localparam int CMD_SAMPLE = 0;
  localparam int CMD_LOAD = 1;
  localparam int ST_DONE = 0;
  localparam int ST_LOADED = 1;
  localparam int ST_WRAP = 2;
  localparam int ST_W = 3;
  typedef enum logic [1:0] {RES10 = 2'h0, RES12 = 2'h1, RES14 = 2'h2, RES16 = 2'h3} res_t;
  typedef enum logic [2:0] {
    S_IDLE = 3'h0, S_FRZ = 3'h1, S_HI = 3'h3, S_LO = 3'h2, S_LOAD = 3'h4
  } state_t;
endpackage

// *** rdc_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface rdc_if;
  import rdc_pkg::*;
  logic resolution_strap_a;
  logic resolution_strap_b;
  logic freezeN;
  logic enableN;
  logic byteSel;
  logic presetN;
  logic invertN;
  logic busy;
  logic dirUp;
  logic wrap;
  logic [POS_W-1:0] devData;
  logic [POS_W-1:0] devOe;
  logic [POS_W-1:0] hostData;
  logic [POS_W-1:0] hostOe;
  logic [POS_W-1:0] position_lines;
  // undriven lines read high, as with a bus pull-up
  assign position_lines = (devOe & devData) | (hostOe & hostData) | ~(devOe | hostOe);
  modport dev (
    input resolution_strap_a, resolution_strap_b, freezeN, enableN, byteSel, presetN,
    input invertN, position_lines,
    output busy, dirUp, wrap, devData, devOe
  );
  modport host (
    output resolution_strap_a, resolution_strap_b, freezeN, enableN, byteSel, presetN,
    output invertN, hostData, hostOe,
    input busy, dirUp, wrap, position_lines
  );
endinterface
`default_nettype wire

// *** pin_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      meta <= INIT;
      q <= INIT;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule
`default_nettype wire

// *** rdc_device.sv ***
`timescale 1ns/1ps
`default_nettype none
module rdc_device #(
  parameter int WIDE = 1
) (
  input wire logic clk_sys,
  input wire logic rst,
  rdc_if.dev link,
  input wire logic trackStep,
  input wire logic trackUp,
  output logic [rdc_pkg::POS_W-1:0] position,
  output logic overspeed
);
  import rdc_pkg::*;

  localparam int NIN = 7 + POS_W;
  localparam logic [NIN-1:0] PIN_INIT = {7'h7b, {POS_W{1'b0}}};
  localparam logic [POS_W-1:0] WIDE_OE = '1;
  localparam logic [POS_W-1:0] NARROW_OE = POS_W'(16'h00ff);

  logic [NIN-1:0] pinRaw;
  logic [NIN-1:0] pinSyn;
  logic [POS_W-1:0] count;
  logic [POS_W-1:0] holdWord;
  logic [7:0] gapCnt;
  logic [7:0] busyCnt;
  logic [7:0] wrapCnt;
  logic busyPin;
  logic wrapPin;
  logic dirPin;
  logic [POS_W-1:0] dataOut;
  logic [POS_W-1:0] oeOut;

  // every pin from the host crosses two flops first
  assign pinRaw = {link.resolution_strap_a, link.resolution_strap_b, link.freezeN,
                   link.enableN, link.byteSel, link.presetN, link.invertN,
                   link.position_lines};

  pin_sync #(
    .W(NIN),
    .INIT(PIN_INIT)
  ) u_pin_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .d(pinRaw),
    .q(pinSyn)
  );

  wire [1:0] strap = pinSyn[NIN-1 -: 2];
  wire frozen = ~pinSyn[NIN-3];
  wire enabled = ~pinSyn[NIN-4];
  wire msbSel = pinSyn[NIN-5];
  wire presetOn = ~pinSyn[NIN-6];
  wire invertOn = ~pinSyn[NIN-7];
  wire [POS_W-1:0] lineIn = pinSyn[POS_W-1:0];

  // narrow variant has no straps and runs fixed at 12 bits
  wire res_t res = (WIDE != 0) ? res_t'(strap) : RES12;
  wire [POS_W-1:0] resMask = (res == RES10) ? MASK10 :
                             (res == RES12) ? MASK12 :
                             (res == RES14) ? MASK14 : MASK16;

  // one step per gap: 1040 rps at 10 bits is the same step rate at every
  // resolution, so one spacing serves all four settings
  wire gapBusy = gapCnt != 8'h00;
  wire stepOk = trackStep && !gapBusy && !presetOn;
  wire stepLost = trackStep && (gapBusy || presetOn);

  wire [POS_W-1:0] cntMasked = count & resMask;
  wire [POS_W-1:0] cntUp = (count + 1'b1) & resMask;
  wire [POS_W-1:0] cntDown = (count - 1'b1) & resMask;
  wire atTop = cntMasked == resMask;
  wire atZero = cntMasked == '0;
  wire wrapNow = stepOk && (trackUp ? atTop : atZero);
  wire [POS_W-1:0] presetVal = lineIn & resMask;
  wire presetChange = presetOn && (presetVal != cntMasked);

  // counter moves on the step itself, no conversion latency
  wire [POS_W-1:0] next_count = presetOn ? presetVal :
                                stepOk ? (trackUp ? cntUp : cntDown) :
                                cntMasked;

  wire [7:0] next_gapCnt = stepOk ? 8'(STEP_GAP_CYC - 1) :
                           gapBusy ? gapCnt - 8'h01 : 8'h00;

  wire changeEv = stepOk || presetChange;
  wire [7:0] next_busyCnt = changeEv ? 8'(BUSY_CYC) :
                            (busyCnt != 8'h00) ? busyCnt - 8'h01 : 8'h00;

  // a plain step or preset change drops any stretched wrap in the cycle the new busy starts
  wire [7:0] next_wrapCnt = wrapNow ? 8'(WRAP_CYC) :
                            changeEv ? 8'h00 :
                            (wrapCnt != 8'h00) ? wrapCnt - 8'h01 : 8'h00;

  wire next_dirPin = stepOk ? trackUp : dirPin;

  // freeze only stops the presented copy; the counter runs on
  wire [POS_W-1:0] next_holdWord = frozen ? holdWord : count;

  wire [POS_W-1:0] shown = (invertOn && WIDE != 0) ? ~holdWord : holdWord;
  wire [BYTE_W-1:0] msByte = shown[POS_W-1 -: BYTE_W];
  wire [BYTE_W-1:0] lsByte = shown[BYTE_W-1:0];
  wire [BYTE_W-1:0] lowLines = msbSel ? msByte : lsByte;
  wire [BYTE_W-1:0] highLines = (WIDE != 0) ? lsByte : 8'h00;
  wire [POS_W-1:0] next_dataOut = {highLines, lowLines};

  // lines stay released while the host drives a preset value
  wire driveOn = enabled && !presetOn;
  wire [POS_W-1:0] next_oeOut = !driveOn ? '0 :
                                (WIDE != 0) ? WIDE_OE : NARROW_OE;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      count <= '0;
      gapCnt <= 8'h00;
      busyCnt <= 8'h00;
      wrapCnt <= 8'h00;
    end else begin
      count <= next_count;
      gapCnt <= next_gapCnt;
      busyCnt <= next_busyCnt;
      wrapCnt <= next_wrapCnt;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      busyPin <= 1'b0;
      wrapPin <= 1'b0;
      dirPin <= 1'b1;
      overspeed <= 1'b0;
    end else begin
      busyPin <= next_busyCnt != 8'h00;
      wrapPin <= next_wrapCnt != 8'h00;
      dirPin <= next_dirPin;
      overspeed <= stepLost;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      holdWord <= '0;
      dataOut <= '0;
      oeOut <= '0;
    end else begin
      holdWord <= next_holdWord;
      dataOut <= next_dataOut;
      oeOut <= next_oeOut;
    end
  end

  assign position = count;
  assign link.devData = dataOut;
  assign link.devOe = oeOut;
  assign link.busy = busyPin;
  assign link.wrap = wrapPin;
  assign link.dirUp = dirPin;
endmodule
`default_nettype wire

// *** rdc_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module rdc_host (
  input wire logic clk_sys,
  input wire logic rst,
  rdc_if.host link,
  input wire logic [rdc_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [rdc_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq
);
  import rdc_pkg::*;

  localparam int NIN = 2 + BYTE_W;

  logic awHeld;
  logic wHeld;
  logic [AXI_AW-1:0] awAddr;
  logic [31:0] wData;
  logic [3:0] wStrb;
  logic [2:0] ctrl;
  logic [POS_W-1:0] presetReg;
  logic [POS_W-1:0] posWord;
  logic [ST_W-1:0] status;
  logic [ST_W-1:0] mask;
  logic wrapPrev;
  logic [7:0] waitCnt;
  state_t state;
  logic [NIN-1:0] pinSyn;

  pin_sync #(
    .W(NIN),
    .INIT('0)
  ) u_pin_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    // busy and the high byte are never read here, so they are not synced
    .d({link.dirUp, link.wrap, link.position_lines[BYTE_W-1:0]}),
    .q(pinSyn)
  );

  wire dirSyn = pinSyn[NIN-1];
  wire wrapSyn = pinSyn[NIN-2];
  wire [BYTE_W-1:0] lowByte = pinSyn[BYTE_W-1:0];

  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready = !wHeld && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  wire doWrite = awHeld && wHeld;
  wire doRead = s_axi_arvalid && s_axi_arready;
  wire [31:0] wMask = {{8{wStrb[3]}}, {8{wStrb[2]}}, {8{wStrb[1]}}, {8{wStrb[0]}}};
  wire [31:0] wBits = wData & wMask;
  wire [3:0] wIdx = awAddr[5:2];
  wire [3:0] rIdx = s_axi_araddr[5:2];
  wire wrCtrl = doWrite && wIdx == REG_CTRL[5:2];
  wire wrCmd = doWrite && wIdx == REG_CMD[5:2];
  wire wrPreset = doWrite && wIdx == REG_PRESET[5:2];
  wire wrStatus = doWrite && wIdx == REG_STATUS[5:2];
  wire wrMask = doWrite && wIdx == REG_MASK[5:2];
  wire wrHit = wrCtrl || wrCmd || wrPreset || wrStatus || wrMask || wIdx == REG_POS[5:2];
  wire fsmIdle = state == S_IDLE;
  wire waitDone = waitCnt == 8'h00;
  wire [31:0] rdVal = (rIdx == REG_CTRL[5:2]) ? {29'h0, ctrl} :
                      (rIdx == REG_PRESET[5:2]) ? {16'h0, presetReg} :
                      (rIdx == REG_POS[5:2]) ? {16'h0, posWord} :
                      (rIdx == REG_STATUS[5:2]) ? {22'h0, dirSyn, !fsmIdle, 5'h0, status} :
                      (rIdx == REG_MASK[5:2]) ? {29'h0, mask} : 32'h0;
  wire rdHit = rIdx <= REG_MASK[5:2] && rIdx != REG_CMD[5:2];

  // commands arriving while a transfer runs are dropped
  wire goSample = wrCmd && fsmIdle && wBits[CMD_SAMPLE];
  wire goLoad = wrCmd && fsmIdle && !wBits[CMD_SAMPLE] && wBits[CMD_LOAD];
  wire evDone = state == S_LO && waitDone;
  wire evLoad = state == S_LOAD && waitDone;
  wire evWrap = wrapSyn && !wrapPrev;
  wire [ST_W-1:0] evAll = {evWrap, evLoad, evDone};
  wire [ST_W-1:0] stClr = wrStatus ? wBits[ST_W-1:0] : '0;
  // set beats clear in the same cycle
  wire [ST_W-1:0] next_status = (status & ~stClr) | evAll;

  // freeze stays low over both byte reads so the bytes match
  assign link.freezeN = !(state == S_FRZ || state == S_HI || state == S_LO);
  assign link.enableN = !(state == S_HI || state == S_LO);
  assign link.byteSel = state == S_HI;
  assign link.presetN = state != S_LOAD;
  assign link.hostOe = (state == S_LOAD) ? '1 : '0;
  assign link.hostData = presetReg;
  assign link.resolution_strap_a = ctrl[1];
  assign link.resolution_strap_b = ctrl[0];
  assign link.invertN = !ctrl[CTRL_INV];

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddr <= '0;
      wData <= 32'h0;
      wStrb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end else if (doWrite) begin
        awHeld <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end else if (doWrite) begin
        wHeld <= 1'b0;
      end
      if (doWrite) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrHit ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
    end else if (doRead) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdVal;
      s_axi_rresp <= rdHit ? 2'h0 : 2'h2;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl <= CTRL_RST;
      presetReg <= '0;
      mask <= '0;
      status <= '0;
      wrapPrev <= 1'b0;
      irq <= 1'b0;
    end else begin
      if (wrCtrl) ctrl <= (ctrl & ~wMask[2:0]) | wBits[2:0];
      if (wrPreset) presetReg <= (presetReg & ~wMask[POS_W-1:0]) | wBits[POS_W-1:0];
      if (wrMask) mask <= (mask & ~wMask[ST_W-1:0]) | wBits[ST_W-1:0];
      status <= next_status;
      wrapPrev <= wrapSyn;
      irq <= |(next_status & mask);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state <= S_IDLE;
      waitCnt <= 8'h00;
      posWord <= '0;
    end else begin
      unique case (state)
        S_IDLE: begin
          if (goSample) begin
            state <= S_FRZ;
            waitCnt <= 8'(FREEZE_CYC - 1);
          end else if (goLoad) begin
            state <= S_LOAD;
            waitCnt <= 8'(LOAD_CYC - 1);
          end
        end
        S_FRZ: begin
          if (waitDone) begin
            state <= S_HI;
            waitCnt <= 8'(READ_CYC - 1);
          end else waitCnt <= waitCnt - 8'h01;
        end
        S_HI: begin
          if (waitDone) begin
            posWord[POS_W-1 -: BYTE_W] <= lowByte;
            state <= S_LO;
            waitCnt <= 8'(READ_CYC - 1);
          end else waitCnt <= waitCnt - 8'h01;
        end
        S_LO: begin
          if (waitDone) begin
            posWord[BYTE_W-1:0] <= lowByte;
            state <= S_IDLE;
          end else waitCnt <= waitCnt - 8'h01;
        end
        S_LOAD: begin
          if (waitDone) state <= S_IDLE;
          else waitCnt <= waitCnt - 8'h01;
        end
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// *** rdc_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module rdc_assertions (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic freezeN,
  input wire logic enableN,
  input wire logic byteSel,
  input wire logic presetN,
  input wire logic busy,
  input wire logic dirUp,
  input wire logic wrap,
  input wire logic [rdc_pkg::POS_W-1:0] devData,
  input wire logic [rdc_pkg::POS_W-1:0] devOe,
  input wire logic [rdc_pkg::POS_W-1:0] hostOe
);
  import rdc_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // device sees host pins two cycles late, so windows span the sync delay
  sequence sReadHeld;
    (!freezeN && !enableN && $stable(byteSel))[*4];
  endsequence
  sequence sBusyPulse;
    busy[*5] ##1 !busy;
  endsequence
  a_oe_released: assert property (enableN[*4] |-> devOe == '0)
    else $error("data lines driven while disabled");
  a_oe_driven: assert property ((!enableN && presetN)[*4] |-> devOe == 16'hffff)
    else $error("data lines not driven while enabled");
  a_ls_byte_dup: assert property ((!enableN && !byteSel && presetN)[*4] |->
    devData[7:0] == devData[15:8])
    else $error("low byte steering wrong");
  a_frozen_stable: assert property (sReadHeld |-> $stable(devData))
    else $error("presented word moved while frozen");
  a_busy_width: assert property ($rose(busy) |-> sBusyPulse)
    else $error("busy pulse width wrong");
  a_wrap_width: assert property ($rose(wrap) |-> wrap[*8] ##1 !wrap)
    else $error("wrap pulse width wrong");
  a_wrap_with_change: assert property ($rose(wrap) |-> ##[0:1] busy)
    else $error("wrap without a position change");
  a_dir_on_step: assert property ($changed(dirUp) |-> ##[0:2] busy)
    else $error("direction moved without a count");
  a_preset_quiet: assert property ((!presetN)[*3] |-> devOe == '0 && hostOe == 16'hffff)
    else $error("bus contention during preset");
  a_freeze_span: assert property (!enableN |-> !freezeN)
    else $error("readout enabled without freeze");
  a_freeze_wait: assert property ($fell(enableN) |-> $past(freezeN, 15) == 1'b0)
    else $error("freeze settle time too short");
endmodule
`default_nettype wire

// *** tb_tracking_position_readout_port.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_tracking_position_readout_port;
  import rdc_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic trackStep = 1'b0;
  logic trackUp = 1'b0;
  logic [POS_W-1:0] position;
  logic overspeed;
  logic ovSeen = 1'b0;
  logic [5:0] awAddr = '0;
  logic awValid = 1'b0;
  logic awReady;
  logic [31:0] wData = '0;
  logic [3:0] wStrb = 4'hf;
  logic wValid = 1'b0;
  logic wReady;
  logic [1:0] bResp;
  logic bValid;
  logic bReady = 1'b1;
  logic [5:0] arAddr = '0;
  logic arValid = 1'b0;
  logic arReady;
  logic [31:0] rData;
  logic [1:0] rResp;
  logic rValid;
  logic rReady = 1'b1;
  logic irq;
  logic [1:0] lastResp;
  logic [15:0] expPos = '0;
  logic [15:0] expMask = 16'hffff;
  int nMismatch = 0;
  int samplesChecked = 0;

  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (overspeed) ovSeen <= 1'b1;

  rdc_if link();
  rdc_device #(.WIDE(1)) u_rdc_device (.clk_sys(clk_sys), .rst(rst), .link(link),
    .trackStep(trackStep), .trackUp(trackUp), .position(position), .overspeed(overspeed));
  rdc_host u_rdc_host (.clk_sys(clk_sys), .rst(rst), .link(link),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
    .s_axi_rready(rReady), .irq(irq));
  rdc_assertions u_rdc_assertions (.clk_sys(clk_sys), .rst(rst), .freezeN(link.freezeN),
    .enableN(link.enableN), .byteSel(link.byteSel), .presetN(link.presetN),
    .busy(link.busy), .dirUp(link.dirUp), .wrap(link.wrap), .devData(link.devData),
    .devOe(link.devOe), .hostOe(link.hostOe));

  task automatic endOfTest();
    $display("comparisons %0d mismatches %0d", samplesChecked, nMismatch);
    if (nMismatch == 0 && samplesChecked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      nMismatch++;
      $display("[ERR] %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // both channels offered together, each dropped once taken
  task automatic wr(input logic [5:0] a, input logic [31:0] v);
    logic aw;
    logic w;
    aw = 1'b0;
    w = 1'b0;
    awAddr <= a;
    wData <= v;
    awValid <= 1'b1;
    wValid <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (awValid && awReady) begin
        aw = 1'b1;
        awValid <= 1'b0;
      end
      if (wValid && wReady) begin
        w = 1'b1;
        wValid <= 1'b0;
      end
    end while (!(aw && w));
    do @(posedge clk_sys); while (bValid !== 1'b1);
    lastResp = bResp;
  endtask

  task automatic rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
    arAddr <= a;
    arValid <= 1'b1;
    do @(posedge clk_sys); while (arReady !== 1'b1);
    arValid <= 1'b0;
    do @(posedge clk_sys); while (rValid !== 1'b1);
    d = rData;
    r = rResp;
  endtask

  task automatic waitStatus(input int b);
    logic [31:0] d;
    logic [1:0] r;
    int n;
    d = '0;
    n = 0;
    while (d[b] !== 1'b1 && n < 200) begin
      rd(REG_STATUS, d, r);
      n++;
    end
    chk({31'h0, d[b]}, 32'h1);
    wr(REG_STATUS, 32'h1 << b);
  endtask

  task automatic step(input logic up);
    trackStep <= 1'b1;
    trackUp <= up;
    @(posedge clk_sys);
    trackStep <= 1'b0;
    expPos = (up ? expPos + 16'h1 : expPos - 16'h1) & expMask;
    cyc(STEP_GAP_CYC + 2);
  endtask

  task automatic preset(input logic [15:0] v);
    wr(REG_PRESET, {16'h0, v});
    wr(REG_CMD, 32'h2);
    waitStatus(ST_LOADED);
    expPos = v & expMask;
  endtask

  // optional step lands while the readout is frozen
  task automatic sample(input logic doStep, output logic [31:0] d);
    logic [1:0] r;
    wr(REG_CMD, 32'h1);
    if (doStep) begin
      cyc(5);
      step(1'b1);
    end
    waitStatus(ST_DONE);
    rd(REG_POS, d, r);
  endtask

  initial begin
    logic [31:0] d;
    logic [1:0] r;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    cyc(4);
    rd(REG_CTRL, d, r);
    chk(d, 32'h3);
    chk({16'h0, link.position_lines}, 32'hffff);
    rd(6'h18, d, r);
    chk({30'h0, r}, 32'h2);
    wr(6'h1c, 32'h5);
    chk({30'h0, lastResp}, 32'h2);
    rd(REG_CMD, d, r);
    chk(d, 32'h0);
    chk({30'h0, r}, 32'h2);
    wr(REG_POS, 32'h5);
    chk({30'h0, lastResp}, 32'h0);
    for (int c = 0; c < 4; c++) begin
      expMask = 16'hffff >> (6 - 2 * c);
      wr(REG_CTRL, 32'(c));
      cyc(4);
      chk({30'h0, link.resolution_strap_a, link.resolution_strap_b}, 32'(c));
      preset(16'hffff);
      chk({16'h0, position}, {16'h0, expPos});
      step(1'b1);
      chk({16'h0, position}, 32'h0);
      chk({31'h0, irq}, 32'h0);
      rd(REG_STATUS, d, r);
      chk(d, 32'h204);
      wr(REG_MASK, 32'h4);
      cyc(2);
      chk({31'h0, irq}, 32'h1);
      wr(REG_STATUS, 32'h4);
      cyc(2);
      chk({31'h0, irq}, 32'h0);
      wr(REG_MASK, 32'h0);
      step(1'b0);
      chk({16'h0, position}, {16'h0, expMask});
      rd(REG_STATUS, d, r);
      chk(d, 32'h4);
      wr(REG_STATUS, 32'h4);
      sample(1'b0, d);
      chk(d, {16'h0, expMask});
    end
    preset(16'h1234);
    sample(1'b1, d);
    chk(d, 32'h1234);
    chk({16'h0, position}, 32'h1235);
    sample(1'b0, d);
    chk(d, 32'h1235);
    wr(REG_CTRL, 32'h7);
    cyc(4);
    chk({31'h0, link.invertN}, 32'h0);
    sample(1'b0, d);
    chk(d, 32'hedca);
    wr(REG_CTRL, 32'h3);
    // second back-to-back step exceeds the tracking rate
    trackStep <= 1'b1;
    trackUp <= 1'b1;
    cyc(2);
    trackStep <= 1'b0;
    cyc(30);
    chk({16'h0, position}, 32'h1236);
    chk({31'h0, ovSeen}, 32'h1);
    endOfTest();
  end

  // run needs under 1000 cycles; allow ten times that
  initial begin
    #400000;
    nMismatch++;
    endOfTest();
  end
endmodule
`default_nettype wire
